// file: rtl/host_irq_status_regs.vh
// Register offsets, bit positions and reset values for the event status block
`ifndef HOST_IRQ_STATUS_REGS_VH
`define HOST_IRQ_STATUS_REGS_VH

// Register offsets
`define OFS_COMMAND_STATUS   8'h08
`define OFS_EVENT_STATUS     8'h0C
`define OFS_EVENT_ENABLE     8'h10
`define OFS_EVENT_DISABLE    8'h14

// Event status bit positions
`define BIT_OVERRUN          0
`define BIT_DONE_HEAD        1
`define BIT_START_FRAME      2
`define BIT_RESUME           3
`define BIT_UNRECOV          4
`define BIT_FRAME_OVF        5
`define BIT_ROOT_HUB         6
`define BIT_OWNERSHIP        30
`define BIT_MASTER_EN        31

// Command status fields
`define BIT_OWN_REQUEST      3
`define BIT_OVR_CNT_LO       16
`define BIT_OVR_CNT_HI       17

// Implemented event bits and reset values
`define EVENT_MASK           32'h4000007F
`define EVENT_STATUS_RST     32'h00000000
`define EVENT_ENABLE_RST     32'h00000000
`define OVR_CNT_RST          2'h0

`endif

// file: rtl/pin_sync3.v
// Three-stage synchroniser with agreement filter for one pin level
`timescale 1ns/10ps
`default_nettype none

module pin_sync3 (
    input wire core_clk_in,
    input wire rstn_in,
    input wire pin_in,
    output reg level_out
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    // First stage feeds only the second stage
    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_out <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_out <= s3_r; // Change counts once two stages agree
            end
        end
    end
endmodule

`default_nettype wire

// file: rtl/usb_host_interrupt_status.v
// Interrupt event status, enables and command status bits of the host core
// What this block does
// - Each event sets its status bit; it stays set until software clears.
// - Interrupt requested when status bit, its enable and master enable set.
// - Writing one to a status bit clears it; other bits untouched.
// - Status register writes never set status bits; zero leaves bits unchanged.
// - Hardware never clears a status bit by itself.
// - Ownership change bit 30 set when request bit 3 set by software.
// - Unmasked ownership change immediately raises management interrupt.
// - Ownership change bit reads zero when that interrupt is absent.
// - Root hub change bit 6 set when hub or port status changes.
// - Frame overflow bit 5 set on counter bit 15 toggle or copy update.
// - Unrecoverable error bit 4 set on system error unrelated to USB.
// - After unrecoverable error, halt list processing and signaling.
// - Resume bit 3 set on transition to downstream resume signaling.
// - Resume bit not set when software enters resume state.
// - Start-of-frame bit 2 set with each SOF token.
// - Done-head bit 1 set right after head pointer write-back.
// - No further done-head write-back while done-head bit is set.
// - Overrun bit 0 set when schedule overruns, after frame copy update.
// - Each overrun increments two-bit counter in command status bits 17:16.
// - Overrun counter starts at zero, wraps, counts even if bit set.
`timescale 1ns/10ps
`default_nettype none
`include "host_irq_status_regs.vh"

module usb_host_interrupt_status #(
    parameter SMI_PRESENT = 1
) (
    input wire core_clk_in,
    input wire rstn_in,
    // Register access port
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    output reg [31:0] reg_rdata_out,
    // Event sources on core clock
    input wire root_hub_status_chg_in,
    input wire root_port_status_chg_in,
    input wire [15:0] frame_counter_in,
    input wire frame_copy_updated_in,
    input wire system_error_in,
    input wire system_error_fixed_in,
    input wire resume_functional_state_in,
    input wire sof_token_in,
    input wire done_head_copied_in,
    input wire sched_overrun_in,
    input wire ownership_changeover_in,
    // Downstream resume signaling pin
    input wire resume_signal_pin_in,
    // Outputs
    output reg irq_out,
    output reg system_mgmt_irq_out,
    output reg processing_halt_out,
    output reg done_head_write_allow_out,
    output reg ownership_change_request_out,
    output reg [1:0] overrun_count_out
);
    localparam [7:0] ST_IRQ_MASK = 8'h7F;

    reg [31:0] status_r;
    reg [31:0] status_nxt;
    reg [31:0] enable_r;
    reg [31:0] enable_nxt;
    reg own_req_r;
    reg [1:0] ovr_cnt_r;
    reg frame_msb_r;
    reg resume_prev_r;
    reg halt_r;
    reg [31:0] set_vec;
    reg [31:0] rd_mux;
    wire resume_level;
    wire [31:0] impl_mask;
    wire wr_status;
    wire wr_enable;
    wire wr_disable;
    wire wr_command;

    // Decode one register offset against the access port
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // Resume pin arrives from the bus side, so it is synchronised
    pin_sync3 pin_sync3_i (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .pin_in(resume_signal_pin_in),
        .level_out(resume_level)
    );

    assign wr_status = reg_wr_in && hit(reg_addr_in, `OFS_EVENT_STATUS);
    assign wr_enable = reg_wr_in && hit(reg_addr_in, `OFS_EVENT_ENABLE);
    assign wr_disable = reg_wr_in && hit(reg_addr_in, `OFS_EVENT_DISABLE);
    assign wr_command = reg_wr_in && hit(reg_addr_in, `OFS_COMMAND_STATUS);

    // Ownership bit exists only with the management interrupt pin
    assign impl_mask = (SMI_PRESENT != 0) ? `EVENT_MASK :
        (`EVENT_MASK & ~(32'h00000001 << `BIT_OWNERSHIP));

    // Collect event set strobes for this cycle
    always @* begin
        set_vec = 32'h00000000;
        set_vec[`BIT_OWNERSHIP] = wr_command &&
            reg_wdata_in[`BIT_OWN_REQUEST];
        set_vec[`BIT_ROOT_HUB] = root_hub_status_chg_in ||
            root_port_status_chg_in;
        set_vec[`BIT_FRAME_OVF] = (frame_counter_in[15] != frame_msb_r) ||
            frame_copy_updated_in;
        set_vec[`BIT_UNRECOV] = system_error_in;
        // Resume entered by software is a state, not a pin edge
        set_vec[`BIT_RESUME] = resume_level && !resume_prev_r &&
            !resume_functional_state_in;
        set_vec[`BIT_START_FRAME] = sof_token_in;
        set_vec[`BIT_DONE_HEAD] = done_head_copied_in &&
            !status_r[`BIT_DONE_HEAD];
        set_vec[`BIT_OVERRUN] = sched_overrun_in;
    end

    // Sticky status: set wins over the write-one clear in the same cycle
    always @* begin
        status_nxt = status_r;
        if (wr_status) begin
            status_nxt = status_nxt & ~reg_wdata_in;
        end
        status_nxt = (status_nxt | set_vec) & impl_mask;
    end

    // Enable register: set port and clear port, both write-one
    always @* begin
        enable_nxt = enable_r;
        if (wr_enable) begin
            enable_nxt = enable_nxt | reg_wdata_in;
        end
        if (wr_disable) begin
            enable_nxt = enable_nxt & ~reg_wdata_in;
        end
        enable_nxt = enable_nxt & (impl_mask |
            (32'h00000001 << `BIT_MASTER_EN));
    end

    // Read data selection
    always @* begin
        rd_mux = 32'h00000000;
        if (hit(reg_addr_in, `OFS_EVENT_STATUS)) begin
            rd_mux = status_r;
        end else if (hit(reg_addr_in, `OFS_EVENT_ENABLE) ||
                     hit(reg_addr_in, `OFS_EVENT_DISABLE)) begin
            rd_mux = enable_r;
        end else if (hit(reg_addr_in, `OFS_COMMAND_STATUS)) begin
            rd_mux[`BIT_OVR_CNT_HI:`BIT_OVR_CNT_LO] = ovr_cnt_r;
            rd_mux[`BIT_OWN_REQUEST] = own_req_r;
        end
    end

    // Next values of the registered outputs
    reg irq_nxt;
    reg smi_nxt;
    reg halt_nxt;
    reg own_req_nxt;
    reg [1:0] ovr_cnt_nxt;
    wire own_req_wr;

    // Any enabled pending event inside a mask, shared by both interrupts
    function pending;
        input [31:0] status;
        input [31:0] enable;
        input [31:0] mask;
        begin
            pending = |(status & enable & mask);
        end
    endfunction

    // Software request strobe for the ownership change
    assign own_req_wr = wr_command && reg_wdata_in[`BIT_OWN_REQUEST];

    // Next-state terms; the two interrupts are taken from the next status and enables
    always @* begin
        // Interrupts follow next state so they rise with the status bit
        irq_nxt = enable_nxt[`BIT_MASTER_EN] &&
            pending(status_nxt, enable_nxt,
            {24'h000000, ST_IRQ_MASK});
        // Ownership change bypasses the normal interrupt path
        smi_nxt = enable_nxt[`BIT_MASTER_EN] &&
            pending(status_nxt, enable_nxt,
            32'h00000001 << `BIT_OWNERSHIP);
        // Error wins over a correction in the same cycle
        halt_nxt = system_error_in ||
            (halt_r && !system_error_fixed_in);
        // Request bit holds until the changeover completes
        own_req_nxt = own_req_wr ||
            (own_req_r && !ownership_changeover_in);
        // Counts every overrun, wrapping, whatever the status bit
        ovr_cnt_nxt = ovr_cnt_r;
        if (sched_overrun_in) begin
            ovr_cnt_nxt = ovr_cnt_r + 2'h1;
        end
    end

    // Sticky event status and the enable register
    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            status_r <= `EVENT_STATUS_RST;
            enable_r <= `EVENT_ENABLE_RST;
        end else begin
            status_r <= status_nxt;
            enable_r <= enable_nxt;
        end
    end

    // Edge history; a reset value of 0 matches the idle level of both
    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            frame_msb_r <= 1'b0;
            resume_prev_r <= 1'b0;
        end else begin
            frame_msb_r <= frame_counter_in[15];
            resume_prev_r <= resume_level;
        end
    end

    // Ownership request bit and its copy on the output pin
    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            own_req_r <= 1'b0;
            ownership_change_request_out <= 1'b0;
        end else begin
            own_req_r <= own_req_nxt;
            ownership_change_request_out <= own_req_nxt;
        end
    end

    // Overrun counter; the output copy is kept in step with the register
    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            ovr_cnt_r <= `OVR_CNT_RST;
            overrun_count_out <= `OVR_CNT_RST;
        end else begin
            ovr_cnt_r <= ovr_cnt_nxt;
            overrun_count_out <= ovr_cnt_nxt;
        end
    end

    // Halt holds from the error until it is corrected
    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            halt_r <= 1'b0;
            processing_halt_out <= 1'b0;
        end else begin
            halt_r <= halt_nxt;
            processing_halt_out <= halt_nxt;
        end
    end

    // Read data is captured only on a read strobe and then stands
    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 32'h00000000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_mux;
        end
    end

    // Interrupt outputs, registered so that they never glitch
    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            irq_out <= 1'b0;
            system_mgmt_irq_out <= 1'b0;
        end else begin
            irq_out <= irq_nxt;
            system_mgmt_irq_out <= smi_nxt;
        end
    end

    // Write-back permission drops while the done-head bit is pending
    // Also held low during reset; allowed again at the first edge after release
    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            done_head_write_allow_out <= 1'b0;
        end else begin
            done_head_write_allow_out <=
                !status_nxt[`BIT_DONE_HEAD];
        end
    end
endmodule

`default_nettype wire

// file: sim/usb_host_interrupt_status_tb.sv
// Directed self-checking bench for the interrupt event status block
`timescale 1ns/10ps
`default_nettype none
module usb_host_interrupt_status_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [8:0] ev = 9'h0;
    logic [15:0] fc = 16'h0;
    logic rfs = 1'b0;
    logic pin = 1'b0;
    logic [1:0] ec = 2'h0;
    wire [31:0] rdat;
    wire irq, smi, halt, dh_ok, own;
    wire [1:0] cnt;
    int num_errors = 0;
    int total_checks = 0;
    // Event bits: 0 ovr 1 dh 2 sof 3 err 4 hub 5 port 6 copy 7 fix 8 chg
    usb_host_interrupt_status usb_host_interrupt_status_i (
        .core_clk_in(clk), .rstn_in(rstn), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(adr), .reg_wdata_in(wd), .reg_rdata_out(rdat),
        .root_hub_status_chg_in(ev[4]), .root_port_status_chg_in(ev[5]),
        .frame_counter_in(fc), .frame_copy_updated_in(ev[6]),
        .system_error_in(ev[3]), .system_error_fixed_in(ev[7]),
        .resume_functional_state_in(rfs), .sof_token_in(ev[2]),
        .done_head_copied_in(ev[1]), .sched_overrun_in(ev[0]),
        .ownership_changeover_in(ev[8]), .resume_signal_pin_in(pin),
        .irq_out(irq), .system_mgmt_irq_out(smi),
        .processing_halt_out(halt), .done_head_write_allow_out(dh_ok),
        .ownership_change_request_out(own), .overrun_count_out(cnt));
    initial forever #2.5 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One-cycle strobe; the idle edge after it avoids double drives
    task automatic acc(input logic w, input [7:0] a, input [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input [7:0] a, input string nm, input [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(nm, rdat, e);
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev <= 9'h1 << i;
        if (i == 0) ec++;
        @(posedge clk);
        ev <= 9'h0;
        #1;
    endtask
    task automatic t_events;
        int bits[7] = '{0, 1, 2, 4, 6, 6, 5};
        for (int i = 0; i < 7; i++) begin
            pulse(i);
            rdchk(8'h0C, "event_bit", 32'h1 << bits[i]);
            acc(1'b1, 8'h0C, 32'h1 << bits[i]);
        end
        chk("halt_held", halt, 1'b1);
        pulse(7);
        chk("halt_end", halt, 1'b0);
        @(posedge clk);
        fc <= 16'h8000;
        rdchk(8'h0C, "frame_ovf", 32'h20);
        acc(1'b1, 8'h0C, 32'h20);
    endtask
    task automatic t_w1c;
        pulse(0);
        pulse(2);
        pulse(4);
        acc(1'b1, 8'h0C, 32'h3FFFFF80);
        repeat (20) @(posedge clk);
        rdchk(8'h0C, "w0_keep", 32'h45);
        acc(1'b1, 8'h0C, 32'h4);
        rdchk(8'h0C, "w1_one", 32'h41);
        acc(1'b1, 8'h0C, 32'hFFFFFFFF);
        rdchk(8'h0C, "w1_all", 32'h0);
    endtask
    task automatic t_irq;
        acc(1'b1, 8'h10, 32'h80000004);
        pulse(2);
        chk("irq_on", irq, 1'b1);
        acc(1'b1, 8'h0C, 32'h4);
        chk("irq_clr", irq, 1'b0);
        acc(1'b1, 8'h14, 32'h80000000);
        pulse(2);
        chk("irq_masked", irq, 1'b0);
        acc(1'b1, 8'h0C, 32'h4);
    endtask
    task automatic t_ovr;
        repeat (5) pulse(0);
        chk("ovr_count", cnt, ec);
        rdchk(8'h08, "cmd_count", {14'h0, ec, 16'h0});
        rdchk(8'h0C, "ovr_bit", 32'h1);
        acc(1'b1, 8'h0C, 32'h1);
    endtask
    task automatic t_done;
        pulse(1);
        pulse(1);
        chk("dh_block", dh_ok, 1'b0);
        acc(1'b1, 8'h0C, 32'h2);
        chk("dh_allow", dh_ok, 1'b1);
    endtask
    task automatic t_own;
        acc(1'b1, 8'h10, 32'hC0000000);
        acc(1'b1, 8'h08, 32'h8);
        chk("own_req", own, 1'b1);
        rdchk(8'h0C, "own_bit", 32'h40000000);
        chk("smi_on", smi, 1'b1);
        pulse(8);
        chk("own_done", own, 1'b0);
        acc(1'b1, 8'h0C, 32'h40000000);
        chk("smi_off", smi, 1'b0);
    endtask
    // Synchroniser latency is 3-4 cycles, so 8 idle cycles suffice
    task automatic t_resume;
        @(posedge clk);
        pin <= 1'b1;
        repeat (8) @(posedge clk);
        rdchk(8'h0C, "resume_bit", 32'h8);
        acc(1'b1, 8'h0C, 32'h8);
        @(posedge clk);
        pin <= 1'b0;
        rfs <= 1'b1;
        repeat (8) @(posedge clk);
        pin <= 1'b1;
        repeat (8) @(posedge clk);
        rdchk(8'h0C, "resume_sw", 32'h0);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence after five reset cycles
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rdchk(8'h0C, "status_rst", 32'h0);
        chk("count_rst", cnt, 2'h0);
        t_events();
        t_w1c();
        t_irq();
        t_ovr();
        t_done();
        t_own();
        t_resume();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// file: sim/usb_irq_status_sva.sv
// Port-level concurrent checks for the interrupt event status block
`timescale 1ns/10ps
`default_nettype none
module usb_irq_status_sva (
    input wire core_clk_in,
    input wire rstn_in,
    input wire reg_wr_in,
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire sched_overrun_in,
    input wire done_head_copied_in,
    input wire system_error_in,
    input wire system_error_fixed_in,
    input wire irq_out,
    input wire system_mgmt_irq_out,
    input wire processing_halt_out,
    input wire done_head_write_allow_out,
    input wire ownership_change_request_out,
    input wire [1:0] overrun_count_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    // Request write and master enable drop
    sequence own_req_wr;
        reg_wr_in && reg_addr_in == 8'h08 && reg_wdata_in[3];
    endsequence
    sequence master_off_wr;
        reg_wr_in && reg_addr_in == 8'h14 && reg_wdata_in[31];
    endsequence
    // Error followed by quiet cycles with no correction
    sequence err_then_quiet;
        system_error_in ##1 !system_error_fixed_in [*3];
    endsequence
    AST_OVR_INC: assert property (
        sched_overrun_in |=>
        overrun_count_out == $past(overrun_count_out) + 2'h1)
        else $error("overrun count did not step");
    AST_OVR_HOLD: assert property (
        !sched_overrun_in |=> $stable(overrun_count_out))
        else $error("overrun count moved without overrun");
    AST_HALT_SET: assert property (
        system_error_in |=> processing_halt_out)
        else $error("halt missing after system error");
    AST_HALT_HOLD: assert property (
        err_then_quiet |=> processing_halt_out)
        else $error("halt dropped before correction");
    AST_DH_BLOCK: assert property (
        done_head_copied_in |=> !done_head_write_allow_out)
        else $error("write-back still allowed after copy");
    // Past reset guard: allow rises at the first edge after release
    AST_DH_STAY: assert property (
        $past(rstn_in) && !done_head_write_allow_out &&
        !(reg_wr_in && reg_addr_in == 8'h0C && reg_wdata_in[1])
        |=> !done_head_write_allow_out)
        else $error("done head flag cleared by hardware");
    AST_OWN_REQ: assert property (
        own_req_wr |=> ownership_change_request_out)
        else $error("ownership request not taken");
    AST_MASTER_OFF: assert property (
        master_off_wr |=> !irq_out && !system_mgmt_irq_out)
        else $error("interrupt with master enable off");
endmodule
bind usb_host_interrupt_status usb_irq_status_sva usb_irq_status_sva_i (.*);
`default_nettype wire
